// [rtc_cal_pkg.sv]
package rtc_cal_pkg;

   // ****************************************
   // register byte addresses (byte address = 4*index)
   // ****************************************
   localparam logic [5:0] HOUR_OFS      = 6'h00;
   localparam logic [5:0] MINUTE_OFS    = 6'h04;
   localparam logic [5:0] SECOND_OFS    = 6'h08;
   localparam logic [5:0] YEAR_OFS      = 6'h0C;
   localparam logic [5:0] MONTH_OFS     = 6'h10;
   localparam logic [5:0] WEEKDAY_OFS   = 6'h14;
   localparam logic [5:0] ALM_DATE_OFS  = 6'h18;
   localparam logic [5:0] ALM_HOUR_OFS  = 6'h1C;
   localparam logic [5:0] ALM_MIN_OFS   = 6'h20;
   localparam logic [5:0] ALM_YEAR_OFS  = 6'h24;
   localparam logic [5:0] CTRL_OFS      = 6'h28;
   localparam logic [5:0] IRQ_STAT_OFS  = 6'h2C;
   localparam logic [5:0] IRQ_CLR_OFS   = 6'h30;
   localparam logic [5:0] IRQ_EN_OFS    = 6'h34;

   // ****************************************
   // implemented-bit masks; reserved bits read zero
   // ****************************************
   localparam logic [7:0] HOUR_MASK     = 8'h3F;
   localparam logic [7:0] MINUTE_MASK   = 8'h7F;
   localparam logic [7:0] SECOND_MASK   = 8'h7F;
   localparam logic [7:0] YEAR_MASK     = 8'hFF;
   localparam logic [7:0] MONTH_MASK    = 8'h1F;
   localparam logic [7:0] WEEKDAY_MASK  = 8'h07;
   localparam logic [7:0] ALM_DATE_MASK = 8'h3F;
   localparam logic [7:0] ALM_HOUR_MASK = 8'h3F;
   localparam logic [7:0] ALM_MIN_MASK  = 8'h7F;
   localparam logic [7:0] ALM_YEAR_MASK = 8'hFF;

   // ****************************************
   // digit limits
   // ****************************************
   localparam logic [3:0] UNITS_MAX     = 4'h9;
   localparam logic [3:0] HOUR_TENS_MAX = 4'h2;
   localparam logic [3:0] MIN_TENS_MAX  = 4'h5;
   localparam logic [3:0] WEEKDAY_MAX   = 4'h6;

   // ****************************************
   // control bits
   // ****************************************
   localparam int CTRL_SNAP_BIT  = 0;
   localparam int CTRL_YEN_BIT   = 1;
   localparam int CTRL_ALARM_MONTH_ENABLE_BIT  = 2;
   localparam int CTRL_DEN_BIT   = 3;
   localparam int CTRL_HEN_BIT   = 4;
   localparam int CTRL_ALARM_MINUTE_ENABLE_BIT  = 5;
   localparam int IRQ_ALARM_BIT  = 0;
   localparam int IRQ_SNAP_BIT   = 1;
   localparam int IRQ_WIDTH      = 2;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam int SNAP_CYCLES    = 2;

   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] weekday;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } cal_t;

   typedef struct packed {
      logic [7:0] date;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] year;
   } alarm_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } bus_req_t;

endpackage

// [rtc_alarm_match.sv]
`timescale 1ns/1ps
module rtc_alarm_match
   import rtc_cal_pkg::*;
(
   input  wire logic   i_clk,
   input  wire logic   i_rst,
   input  wire cal_t   i_live,
   input  wire alarm_t i_alarm,
   input  wire logic   i_year_en,
   input  wire logic   i_month_en,
   input  wire logic   i_date_en,
   input  wire logic   i_hour_en,
   input  wire logic   i_minute_en,
   input  wire logic   [7:0] i_alarm_month,
   output logic        o_event
);

   typedef struct packed {
      logic match;
   } match_state_t;

   match_state_t st_r;
   match_state_t st_nxt;
   logic         hit;
   logic         any_en;

   // ****************************************
   // compare enabled fields, one event per new match
   // ****************************************
   always_comb
   begin
      any_en = i_year_en | i_month_en | i_date_en | i_hour_en | i_minute_en;
      hit = any_en
         & (!i_year_en   || i_alarm.year   == i_live.year)
         & (!i_month_en  || i_alarm_month  == i_live.month)
         & (!i_date_en   || i_alarm.date   == i_live.date)
         & (!i_hour_en   || i_alarm.hour   == i_live.hour)
         & (!i_minute_en || i_alarm.minute == i_live.minute);
      st_nxt.match = hit;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign o_event = hit & ~st_r.match;

endmodule

// [rtc_calendar_alarm_regs.sv]
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module rtc_calendar_alarm_regs
   import rtc_cal_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic [5:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire cal_t       i_live,
   input  wire logic [7:0] i_alarm_month,
   output logic [7:0]      o_rdata,
   output cal_t            o_cal_set,
   output logic            o_cal_load,
   output logic            o_irq
);

   // ****************************************
   // state
   // ****************************************
   typedef enum {SNAP_IDLE, SNAP_WAIT, SNAP_COPY} snap_state_t;

   typedef struct packed {
      cal_t                 cal;
      alarm_t               alarm;
      logic [5:0]           ctrl;
      logic [IRQ_WIDTH-1:0] stat;
      logic [IRQ_WIDTH-1:0] en;
      logic [7:0]           rdata;
      logic                 load;
      logic [1:0]           snap_cnt;
      snap_state_t          snap;
   } state_t;

   state_t     s_r;
   state_t     s_nxt;
   bus_req_t   req;
   logic       alarm_ev;
   logic [7:0] w;

   assign req.wr    = i_wr;
   assign req.rd    = i_rd;
   assign req.addr  = i_addr;
   assign req.wdata = i_wdata;

   // ****************************************
   // digit checks
   // ****************************************
   // units digit of every BCD field except weekday, codes A-F refused
   function automatic logic units_ok(input logic [7:0] v);
      units_ok = (v[3:0] <= UNITS_MAX);
   endfunction

   function automatic logic digits_ok(input logic [7:0] v,
                                      input logic [3:0] tens_max);
      digits_ok = units_ok(v) && ({1'b0, v[6:4]} <= tens_max)
                  && !v[7];
   endfunction

   // two-bit tens digit, code 3 refused
   function automatic logic hour_ok(input logic [7:0] v);
      hour_ok = units_ok(v) && ({2'b00, v[5:4]} <= HOUR_TENS_MAX);
   endfunction

   function automatic logic year_ok(input logic [7:0] v);
      year_ok = (v[3:0] <= UNITS_MAX) && (v[7:4] <= UNITS_MAX);
   endfunction

   // ****************************************
   // alarm comparator
   // ****************************************
   rtc_alarm_match rtc_alarm_match_inst
   (
      .i_clk         (i_clk),
      .i_rst         (i_rst),
      .i_live        (i_live),
      .i_alarm       (s_r.alarm),
      .i_year_en     (s_r.ctrl[CTRL_YEN_BIT]),
      .i_month_en    (s_r.ctrl[CTRL_ALARM_MONTH_ENABLE_BIT]),
      .i_date_en     (s_r.ctrl[CTRL_DEN_BIT]),
      .i_hour_en     (s_r.ctrl[CTRL_HEN_BIT]),
      .i_minute_en   (s_r.ctrl[CTRL_ALARM_MINUTE_ENABLE_BIT]),
      .i_alarm_month (i_alarm_month),
      .o_event       (alarm_ev)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.load = 1'b0;
      w          = req.wdata;

      if (req.wr)
      begin
         case (req.addr)
            HOUR_OFS:
               if (hour_ok(w))
               begin
                  s_nxt.cal.hour = w & HOUR_MASK;
                  s_nxt.load     = 1'b1;
               end
            MINUTE_OFS:
               if (digits_ok(w & MINUTE_MASK, MIN_TENS_MAX))
               begin
                  s_nxt.cal.minute = w & MINUTE_MASK;
                  s_nxt.load       = 1'b1;
               end
            SECOND_OFS:
               if (digits_ok(w & SECOND_MASK, MIN_TENS_MAX))
               begin
                  s_nxt.cal.second = w & SECOND_MASK;
                  s_nxt.load       = 1'b1;
               end
            YEAR_OFS:
               if (year_ok(w))
               begin
                  s_nxt.cal.year = w & YEAR_MASK;
                  s_nxt.load     = 1'b1;
               end
            MONTH_OFS:
               if (w[3:0] <= UNITS_MAX)
               begin
                  s_nxt.cal.month = w & MONTH_MASK;
                  s_nxt.load      = 1'b1;
               end
            WEEKDAY_OFS:
               if ({1'b0, w[2:0]} <= WEEKDAY_MAX)
               begin
                  s_nxt.cal.weekday = w & WEEKDAY_MASK;
                  s_nxt.load        = 1'b1;
               end
            ALM_DATE_OFS:
               if (w[3:0] <= UNITS_MAX)
                  s_nxt.alarm.date = w & ALM_DATE_MASK;
            ALM_HOUR_OFS:
               if (hour_ok(w))
                  s_nxt.alarm.hour = w & ALM_HOUR_MASK;
            ALM_MIN_OFS:
               if (digits_ok(w & ALM_MIN_MASK, MIN_TENS_MAX))
                  s_nxt.alarm.minute = w & ALM_MIN_MASK;
            ALM_YEAR_OFS:
               if (year_ok(w))
                  s_nxt.alarm.year = w & ALM_YEAR_MASK;
            CTRL_OFS:
            begin
               s_nxt.ctrl[5:1] = w[5:1];
               if (w[CTRL_SNAP_BIT] && s_r.snap == SNAP_IDLE)
               begin
                  s_nxt.ctrl[CTRL_SNAP_BIT] = 1'b1;
                  s_nxt.snap     = SNAP_WAIT;
                  s_nxt.snap_cnt = 2'(SNAP_CYCLES - 1);
               end
            end
            IRQ_CLR_OFS:
               s_nxt.stat = s_r.stat & ~w[IRQ_WIDTH-1:0];
            IRQ_EN_OFS:
               s_nxt.en = w[IRQ_WIDTH-1:0];
            default:
               s_nxt.stat = s_nxt.stat;
         endcase
      end

      // ****************************************
      // snapshot sequence: settle, then copy
      // ****************************************
      case (s_r.snap)
         SNAP_IDLE:
            s_nxt.snap_cnt = s_nxt.snap_cnt;
         SNAP_WAIT:
            if (s_r.snap_cnt == 2'h0)
               s_nxt.snap = SNAP_COPY;
            else
               s_nxt.snap_cnt = s_r.snap_cnt - 2'h1;
         SNAP_COPY:
         begin
            s_nxt.cal = i_live;
            s_nxt.cal.hour    = i_live.hour & HOUR_MASK;
            s_nxt.cal.minute  = i_live.minute & MINUTE_MASK;
            s_nxt.cal.second  = i_live.second & SECOND_MASK;
            s_nxt.cal.month   = i_live.month & MONTH_MASK;
            s_nxt.cal.weekday = i_live.weekday & WEEKDAY_MASK;
            s_nxt.ctrl[CTRL_SNAP_BIT] = 1'b0;
            s_nxt.snap = SNAP_IDLE;
            s_nxt.stat[IRQ_SNAP_BIT] = 1'b1;
         end
         default:
            s_nxt.snap = SNAP_IDLE;
      endcase

      // ****************************************
      // event flags, set wins over clear
      // ****************************************
      if (alarm_ev)
         s_nxt.stat[IRQ_ALARM_BIT] = 1'b1;

      // ****************************************
      // read data, one cycle later
      // ****************************************
      s_nxt.rdata = RESET_VALUE;
      if (req.rd)
      begin
         case (req.addr)
            HOUR_OFS:     s_nxt.rdata = s_r.cal.hour & HOUR_MASK;
            MINUTE_OFS:   s_nxt.rdata = s_r.cal.minute & MINUTE_MASK;
            SECOND_OFS:   s_nxt.rdata = s_r.cal.second & SECOND_MASK;
            YEAR_OFS:     s_nxt.rdata = s_r.cal.year;
            MONTH_OFS:    s_nxt.rdata = s_r.cal.month & MONTH_MASK;
            WEEKDAY_OFS:  s_nxt.rdata = s_r.cal.weekday & WEEKDAY_MASK;
            ALM_DATE_OFS: s_nxt.rdata = s_r.alarm.date & ALM_DATE_MASK;
            ALM_HOUR_OFS: s_nxt.rdata = s_r.alarm.hour & ALM_HOUR_MASK;
            ALM_MIN_OFS:  s_nxt.rdata = s_r.alarm.minute & ALM_MIN_MASK;
            ALM_YEAR_OFS: s_nxt.rdata = s_r.alarm.year;
            CTRL_OFS:     s_nxt.rdata = {2'b00, s_r.ctrl};
            IRQ_STAT_OFS: s_nxt.rdata = {6'h00, s_r.stat};
            IRQ_EN_OFS:   s_nxt.rdata = {6'h00, s_r.en};
            default:      s_nxt.rdata = RESET_VALUE;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s_r      <= '0;
         s_r.snap <= SNAP_IDLE;
      end
      else
         s_r <= s_nxt;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign o_rdata    = s_r.rdata;
   assign o_cal_set  = s_r.cal;
   assign o_cal_load = s_r.load;
   assign o_irq      = |(s_r.stat & s_r.en);

endmodule

// [rtc_calendar_alarm_regs_chk.sv]
`timescale 1ns/1ps
module rtc_calendar_alarm_regs_chk
   import rtc_cal_pkg::*;
(
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic [5:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire cal_t       i_live,
   input wire logic [7:0] i_alarm_month,
   input wire logic [7:0] o_rdata,
   input wire cal_t       o_cal_set,
   input wire logic       o_cal_load,
   input wire logic       o_irq
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // ****************
   // assertions
   // ****************
   chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside read cycle");
   chk_hour_digits: assert property (o_cal_set.hour[7:6] == 2'b00
      && o_cal_set.hour[5:4] != 2'b11 && o_cal_set.hour[3:0] <= UNITS_MAX)
      else $error("hour holds an illegal code");
   chk_minute_digits: assert property (!o_cal_set.minute[7]
      && {1'b0, o_cal_set.minute[6:4]} <= MIN_TENS_MAX
      && o_cal_set.minute[3:0] <= UNITS_MAX)
      else $error("minute holds an illegal code");
   chk_second_digits: assert property (!o_cal_set.second[7]
      && {1'b0, o_cal_set.second[6:4]} <= MIN_TENS_MAX
      && o_cal_set.second[3:0] <= UNITS_MAX)
      else $error("second holds an illegal code");
   chk_year_digits: assert property (o_cal_set.year[7:4] <= UNITS_MAX
      && o_cal_set.year[3:0] <= UNITS_MAX)
      else $error("year holds an illegal code");
   chk_month_digits: assert property (o_cal_set.month[7:5] == 3'b000
      && o_cal_set.month[3:0] <= UNITS_MAX)
      else $error("month holds an illegal code");
   chk_weekday_code: assert property (o_cal_set.weekday <= 8'h06)
      else $error("weekday holds an illegal code");
   chk_load_cause: assert property (o_cal_load |-> $past(i_wr)
      && $past(i_addr) <= WEEKDAY_OFS)
      else $error("load pulse without a time register write");
   chk_hour_write: assert property (i_wr && i_addr == HOUR_OFS
      && i_wdata[7:6] == 2'b00 && i_wdata[5:4] != 2'b11
      && i_wdata[3:0] <= UNITS_MAX |=> o_cal_set.hour == $past(i_wdata))
      else $error("legal hour write not stored");
   chk_alm_min_read: assert property (i_rd && i_addr == ALM_MIN_OFS
      |=> !o_rdata[7] && o_rdata[6:4] <= 3'h5)
      else $error("alarm minute read shows illegal bits");
endmodule
bind rtc_calendar_alarm_regs rtc_calendar_alarm_regs_chk chk_inst (
   .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .i_live(i_live),
   .i_alarm_month(i_alarm_month), .o_rdata(o_rdata),
   .o_cal_set(o_cal_set), .o_cal_load(o_cal_load), .o_irq(o_irq));

// [rtc_calendar_alarm_regs_tb.sv]
`timescale 1ns/1ps
module rtc_calendar_alarm_regs_tb;
   import rtc_cal_pkg::*;
   logic        i_clk;
   logic        i_rst;
   logic [5:0]  i_addr;
   logic [7:0]  i_wdata;
   logic        i_wr;
   logic        i_rd;
   cal_t        i_live;
   logic [7:0]  i_alarm_month;
   logic [7:0]  o_rdata;
   cal_t        o_cal_set;
   logic        o_cal_load;
   logic        o_irq;
   int          n_errors;
   int          checks;
   logic [21:0] tbl [27];

   rtc_calendar_alarm_regs rtc_calendar_alarm_regs_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_live(i_live),
      .i_alarm_month(i_alarm_month),
      .o_rdata(o_rdata), .o_cal_set(o_cal_set), .o_cal_load(o_cal_load),
      .o_irq(o_irq));

   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      check(o_rdata, e);
   endtask

   // interrupt line given two edges to settle from the registers
   task automatic irq_is(input logic e);
      repeat (2) @(posedge i_clk);
      #1;
      check({7'h00, o_irq}, {7'h00, e});
   endtask

   task automatic test_done;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge i_clk);
      n_errors++;
      test_done;
   end

   // ****************
   // tests
   // ****************
   initial
   begin
      tbl = '{{HOUR_OFS, 16'h2323}, {HOUR_OFS, 16'h3023},
         {HOUR_OFS, 16'h1A23}, {MINUTE_OFS, 16'h5959},
         {MINUTE_OFS, 16'h6059}, {MINUTE_OFS, 16'hC545},
         {SECOND_OFS, 16'h3737}, {SECOND_OFS, 16'h7037},
         {SECOND_OFS, 16'h5A37}, {YEAR_OFS, 16'h9999},
         {YEAR_OFS, 16'hA099}, {MONTH_OFS, 16'h1212},
         {MONTH_OFS, 16'h1F12}, {MONTH_OFS, 16'hE909},
         {WEEKDAY_OFS, 16'h0606}, {WEEKDAY_OFS, 16'h0706},
         {WEEKDAY_OFS, 16'h0D05}, {ALM_DATE_OFS, 16'h3939},
         {ALM_DATE_OFS, 16'hC101}, {ALM_DATE_OFS, 16'h0B01},
         {ALM_HOUR_OFS, 16'h1919}, {ALM_HOUR_OFS, 16'h3019},
         {ALM_MIN_OFS, 16'h5959}, {ALM_MIN_OFS, 16'h6059},
         {ALM_MIN_OFS, 16'h9212}, {ALM_YEAR_OFS, 16'h4545},
         {ALM_YEAR_OFS, 16'h4F45}};
      i_rst = 1'b1;
      i_addr = 6'h00;
      i_wdata = 8'h00;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_live = '0;
      i_alarm_month = 8'h00;
      n_errors = 0;
      checks = 0;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int i = 0; i < 10; i++)
         rd(6'(4 * i), 8'h00);
      rd(6'h38, 8'h00);
      $display("test reset values done");
      foreach (tbl[i])
      begin
         wr(tbl[i][21:16], tbl[i][15:8]);
         rd(tbl[i][21:16], tbl[i][7:0]);
      end
      wr(HOUR_OFS, 8'h21);
      #1 check({7'h00, o_cal_load}, 8'h01);
      wr(HOUR_OFS, 8'h3F);
      #1 check({7'h00, o_cal_load}, 8'h00);
      $display("test field limits done");
      @(posedge i_clk);
      i_live <= '{8'h24, 8'h11, 8'h28, 8'h03, 8'h20, 8'h47, 8'h58};
      wr(CTRL_OFS, 8'h01);
      repeat (6) @(posedge i_clk);
      rd(CTRL_OFS, 8'h00);
      rd(HOUR_OFS, 8'h20);
      rd(MINUTE_OFS, 8'h47);
      rd(SECOND_OFS, 8'h58);
      rd(YEAR_OFS, 8'h24);
      rd(MONTH_OFS, 8'h11);
      rd(WEEKDAY_OFS, 8'h03);
      check(o_cal_set.date, 8'h28);
      rd(IRQ_STAT_OFS, 8'h02);
      wr(IRQ_EN_OFS, 8'h02);
      irq_is(1'b1);
      wr(IRQ_EN_OFS, 8'h00);
      irq_is(1'b0);
      wr(IRQ_EN_OFS, 8'h02);
      wr(IRQ_CLR_OFS, 8'h02);
      irq_is(1'b0);
      rd(IRQ_STAT_OFS, 8'h00);
      $display("test snapshot done");
      wr(ALM_HOUR_OFS, 8'h21);
      wr(ALM_MIN_OFS, 8'h47);
      wr(CTRL_OFS, 8'h30);
      repeat (3) @(posedge i_clk);
      rd(IRQ_STAT_OFS, 8'h00);
      @(posedge i_clk);
      i_live.hour <= 8'h21;
      repeat (4) @(posedge i_clk);
      rd(IRQ_STAT_OFS, 8'h01);
      wr(IRQ_EN_OFS, 8'h01);
      irq_is(1'b1);
      wr(CTRL_OFS, 8'h00);
      wr(IRQ_CLR_OFS, 8'h01);
      irq_is(1'b0);
      $display("test alarm done");
      wr(ALM_YEAR_OFS, 8'h24);
      wr(ALM_DATE_OFS, 8'h28);
      @(posedge i_clk);
      i_alarm_month <= 8'h12;
      wr(CTRL_OFS, 8'h0E);
      repeat (3) @(posedge i_clk);
      rd(IRQ_STAT_OFS, 8'h00);
      @(posedge i_clk);
      i_live.month <= 8'h12;
      repeat (4) @(posedge i_clk);
      rd(IRQ_STAT_OFS, 8'h01);
      irq_is(1'b1);
      wr(CTRL_OFS, 8'h00);
      wr(IRQ_CLR_OFS, 8'h01);
      irq_is(1'b0);
      $display("test alarm date month year done");
      @(posedge i_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int i = 0; i < 10; i++)
         rd(6'(4 * i), 8'h00);
      rd(IRQ_EN_OFS, 8'h00);
      irq_is(1'b0);
      $display("test second reset done");
      test_done;
   end
endmodule
